// ---- verilog/aqs_pkg.sv ----
`default_nettype none
package aqs_pkg;
  localparam int CLK_NS = 20;
  localparam int NCH    = 32;
  localparam int DW     = 12;
  localparam int CNT_W  = 10;

  // Byte addresses of the register window.
  localparam logic [8:0] OFS_CTL   = 9'h000;
  localparam logic [8:0] OFS_CONV  = 9'h004;
  localparam logic [8:0] OFS_RES   = 9'h008;
  localparam logic [8:0] OFS_STAT  = 9'h00C;
  localparam logic [8:0] OFS_SCTL  = 9'h010;
  localparam logic [8:0] OFS_STMR  = 9'h014;
  localparam logic [8:0] OFS_SSTAT = 9'h018;
  localparam logic [1:0] RAM_INSTR = 2'h1;
  localparam logic [1:0] RAM_DATA  = 2'h2;
  localparam logic [8:0] ADR_MASK  = 9'h1FC;

  // Acquisition control fields.
  localparam int CTL_CH_LSB   = 0;
  localparam int CTL_DIFF_BIT = 5;
  localparam int CTL_GAIN_LSB = 6;
  localparam int CTL_AUTO_BIT = 8;
  localparam int CTL_PIPE_BIT = 9;
  localparam int CTL_IE_BIT   = 10;
  localparam int CTL_W        = 11;

  // Status, sequencer control and sequencer status fields.
  localparam int STAT_CONV_BIT   = 0;
  localparam int STAT_SETTLE_BIT = 1;
  localparam int SCTL_RUN_BIT    = 0;
  localparam int SCTL_IE_BIT     = 1;
  localparam int SST_AVAIL_BIT   = 0;
  localparam int SST_OVF_BIT     = 1;
  localparam int SST_TERR_BIT    = 2;
  localparam int SST_IERR_BIT    = 3;

  // Instruction word fields.
  localparam int INS_GAIN_LSB = 0;
  localparam int INS_DIFF_BIT = 2;
  localparam int INS_EN_BIT   = 3;

  // Reset values.
  localparam logic [10:0] CTL_RST  = 11'h000;
  localparam logic [15:0] STMR_RST = 16'h0000;

  // Timing in nanoseconds and the derived cycle counts, rounded up.
  localparam int SETTLE_NS      = 7500;
  localparam int AUTO_SETTLE_NS = 17500;
  localparam int AUTO_PIPE_NS   = 7500;
  localparam int CONV_NS        = 12500;
  localparam int SEQ_STEP_NS    = 100000;
  localparam logic [CNT_W-1:0] SETTLE_CYC =
    CNT_W'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] AUTO_SETTLE_CYC =
    CNT_W'((AUTO_SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] AUTO_PIPE_CYC =
    CNT_W'((AUTO_PIPE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] CONV_CYC =
    CNT_W'((CONV_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_SETTLE,
    SQ_CONV,
    SQ_WAIT
  } aqs_seq_t;
endpackage : aqs_pkg
`default_nettype wire

// ---- verilog/aqs_tick_div.sv ----
`default_nettype none
module aqs_tick_div #(
  parameter int TICK_CYC = 5000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic clr,
  output var  logic tick_o
);
  logic [15:0] cnt_r;
  wire         last_w = (cnt_r == 16'(TICK_CYC - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      cnt_r  <= (clr || last_w) ? 16'h0000 : cnt_r + 16'h0001;
      tick_o <= !clr && last_w;
    end
  end
endmodule : aqs_tick_div
`default_nettype wire

// ---- verilog/aqs_sequencer.sv ----
// Functional notes
// - Auto and pipeline bits pick four modes
// - Control write, auto clear: normal, apply settings
// - Convert write starts; pipeline gives previous result
// - Auto bit: conversion starts after settling
// - Settling flag high until settle time ends
// - Conversion flag low only with valid result
// - Control write accepted during ongoing conversion
// - Normal mode: settle and conversion interrupts
// - Auto mode: one interrupt at conversion end
// - Normal timing 20us, pipelined 12.5us
// - Auto timing 30us, pipelined 20us
// - One instruction word per channel
// - Enabled channels ascending, stored at end
// - Sequence end sets data available, interrupts
// - Only enabled channels' data locations change
// - Data available cleared by writing one
// - Repeat timer in 100us steps
// - Timer zero means continuous sequencing
// - Continuous mode writes results immediately
// - Update period bounded by channel count
// - Errors stop sequencer, set write-one-clear flags
// - Continuous mode ignores overflow, reads zero
`default_nettype none
module aqs_sequencer #(
  parameter int STEP_CYC = aqs_pkg::SEQ_STEP_NS / aqs_pkg::CLK_NS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [8:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // Converter and input multiplexer
  input  wire logic [11:0] adc_data_i,
  output var  logic [4:0]  mux_chan_o,
  output var  logic        mux_diff_o,
  output var  logic [1:0]  gain_o,
  output var  logic        adc_start_o,
  // Interrupt request pulse
  output var  logic        irq_o
);
  localparam int CW = aqs_pkg::CNT_W;

  function automatic logic [5:0] find_enabled(input logic [31:0] en,
                                              input logic [5:0]  from);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (en[i] && (6'(i) >= from)) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction : find_enabled

  // Register state.
  logic [10:0]     ctl_r;
  logic [11:0]     result_r;
  logic [11:0]     prev_r;
  logic            run_r;
  logic            sie_r;
  logic [15:0]     stmr_r;
  logic            avail_r;
  logic            ovf_r;
  logic            terr_r;
  logic            ierr_r;
  logic            terr_pend_r;
  logic [CW-1:0]   settle_cnt_r;
  logic [CW-1:0]   conv_cnt_r;
  logic            settle_seq_r;
  logic            conv_seq_r;
  logic [15:0]     pcnt_r;
  logic [4:0]      cur_r;
  aqs_pkg::aqs_seq_t sq_r;
  aqs_pkg::aqs_seq_t sq_nxt;
  logic [3:0]      iram_r [aqs_pkg::NCH];
  logic [11:0]     shadow_r [aqs_pkg::NCH];
  logic [11:0]     dram_r [aqs_pkg::NCH];
  logic [31:0]     ena;
  logic [31:0]     rd_nxt;
  logic            tick;

  // Bus decode: a write takes effect at the edge where ack is high.
  wire       req     = wb_cyc_i && wb_stb_i;
  wire [8:0] adr     = wb_adr_i & aqs_pkg::ADR_MASK;
  wire       wr      = req && wb_we_i && wb_ack_o && (wb_sel_i[1:0] == 2'h3);
  wire       wr_ctl  = wr && (adr == aqs_pkg::OFS_CTL);
  wire       wr_conv = wr && (adr == aqs_pkg::OFS_CONV);
  wire       wr_sctl = wr && (adr == aqs_pkg::OFS_SCTL);
  wire       wr_stmr = wr && (adr == aqs_pkg::OFS_STMR);
  wire       wr_sst  = wr && (adr == aqs_pkg::OFS_SSTAT);
  wire       wr_iram = wr && (adr[8:7] == aqs_pkg::RAM_INSTR);
  wire [4:0] ridx    = adr[6:2];

  wire auto_m  = ctl_r[aqs_pkg::CTL_AUTO_BIT];
  wire pipe_m  = ctl_r[aqs_pkg::CTL_PIPE_BIT];
  wire ie_m    = ctl_r[aqs_pkg::CTL_IE_BIT];
  wire cont_m  = (stmr_r == 16'h0000);
  wire seq_on  = (sq_r != aqs_pkg::SQ_IDLE);

  wire settle_active = (settle_cnt_r != '0);
  wire settle_done   = (settle_cnt_r == CW'(1));
  wire settle_ok     = (settle_cnt_r <= CW'(1));
  wire conv_active   = (conv_cnt_r != '0);
  wire conv_done     = (conv_cnt_r == CW'(1));

  // Conventional path; a control write is taken even mid-conversion.
  wire ctl_take  = wr_ctl && !seq_on;
  wire wr_auto   = wb_dat_i[aqs_pkg::CTL_AUTO_BIT];
  wire wr_pipe   = wb_dat_i[aqs_pkg::CTL_PIPE_BIT];
  wire cnv_take  = wr_conv && !seq_on && !auto_m && !conv_active;
  wire auto_go   = settle_done && !settle_seq_r && auto_m && !seq_on;
  wire conv_evt  = conv_done && !conv_seq_r;
  wire [CW-1:0] ctl_settle = !wr_auto ? aqs_pkg::SETTLE_CYC :
                             wr_pipe ? aqs_pkg::AUTO_PIPE_CYC :
                                       aqs_pkg::AUTO_SETTLE_CYC;

  // Sequencer decode.
  wire [5:0] first     = find_enabled(ena, 6'h00);
  wire [5:0] after_cur = find_enabled(ena, {1'b0, cur_r} + 6'h01);
  wire       run_req   = wr_sctl && wb_dat_i[aqs_pkg::SCTL_RUN_BIT];
  wire       seq_start = run_req && !seq_on && first[5];
  wire       ierr_set  = run_req && !seq_on && !first[5];
  wire       in_settle = (sq_r == aqs_pkg::SQ_SETTLE);
  wire       in_conv   = (sq_r == aqs_pkg::SQ_CONV);
  wire       seq_store = in_conv && conv_done;
  wire       seq_end   = seq_store && !after_cur[5];
  wire       seq_go    = (in_settle && settle_ok) ||
                         (seq_store && after_cur[5]);
  wire [4:0] conv_ch   = in_conv ? after_cur[4:0] : cur_r;
  wire [5:0] tgt_after = find_enabled(ena, {1'b0, conv_ch} + 6'h01);
  wire [4:0] seq_tgt   = (seq_go && tgt_after[5]) ? tgt_after[4:0] :
                         first[4:0];
  wire       timed     = seq_on && !cont_m;
  wire       period_hit = timed && tick &&
                          (pcnt_r + 16'h0001 == stmr_r);
  wire       terr_set  = period_hit && (sq_r != aqs_pkg::SQ_WAIT);
  wire       ovf_set   = seq_end && !cont_m && avail_r;
  wire       halt      = seq_end &&
                         (!run_r || ovf_set || terr_pend_r || terr_set);
  // A repeated sequence must settle on the first channel again.
  wire       rearm     = (seq_end && !halt && cont_m) ||
                         ((sq_r == aqs_pkg::SQ_WAIT) && run_r &&
                          period_hit);
  wire       seq_mux   = seq_start || rearm || seq_go;
  wire       commit    = seq_end && !cont_m;
  wire       clr_avail = wr_sst && wb_dat_i[aqs_pkg::SST_AVAIL_BIT];
  wire       clr_ovf   = wr_sst && wb_dat_i[aqs_pkg::SST_OVF_BIT];
  wire       clr_terr  = wr_sst && wb_dat_i[aqs_pkg::SST_TERR_BIT];
  wire       clr_ierr  = wr_sst && wb_dat_i[aqs_pkg::SST_IERR_BIT];
  wire [3:0] tgt_word  = iram_r[seq_tgt];

  wire irq_nxt = (ie_m && !auto_m && settle_done && !settle_seq_r) ||
                 (ie_m && conv_evt) ||
                 (sie_r && (seq_end || ierr_set || terr_set));

  always_comb begin
    sq_nxt = sq_r;
    unique case (sq_r)
      aqs_pkg::SQ_IDLE: begin
        if (seq_start) begin
          sq_nxt = aqs_pkg::SQ_SETTLE;
        end
      end
      aqs_pkg::SQ_SETTLE: begin
        if (settle_ok) begin
          sq_nxt = aqs_pkg::SQ_CONV;
        end
      end
      aqs_pkg::SQ_CONV: begin
        if (halt) begin
          sq_nxt = aqs_pkg::SQ_IDLE;
        end else if (seq_end) begin
          sq_nxt = cont_m ? aqs_pkg::SQ_SETTLE : aqs_pkg::SQ_WAIT;
        end
      end
      aqs_pkg::SQ_WAIT: begin
        if (!run_r) begin
          sq_nxt = aqs_pkg::SQ_IDLE;
        end else if (period_hit) begin
          sq_nxt = aqs_pkg::SQ_SETTLE;
        end
      end
    endcase
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (adr[8:7] == aqs_pkg::RAM_INSTR) begin
      rd_nxt = {28'h000_0000, iram_r[ridx]};
    end else if (adr[8:7] == aqs_pkg::RAM_DATA) begin
      rd_nxt = {20'h0_0000, dram_r[ridx]};
    end else if (adr == aqs_pkg::OFS_CTL) begin
      rd_nxt = {21'h00_0000, ctl_r};
    end else if (adr == aqs_pkg::OFS_RES) begin
      rd_nxt = {20'h0_0000, result_r};
    end else if (adr == aqs_pkg::OFS_STAT) begin
      rd_nxt = {30'h0000_0000, settle_active, conv_active};
    end else if (adr == aqs_pkg::OFS_SCTL) begin
      rd_nxt = {30'h0000_0000, sie_r, run_r};
    end else if (adr == aqs_pkg::OFS_STMR) begin
      rd_nxt = {16'h0000, stmr_r};
    end else if (adr == aqs_pkg::OFS_SSTAT) begin
      rd_nxt = {27'h000_0000, seq_on, ierr_r, terr_r,
                ovf_r && !cont_m, avail_r};
    end
  end

  aqs_tick_div #(
    .TICK_CYC (STEP_CYC)
  ) u_tick (
    .clk    (clk),
    .rst    (rst),
    .clr    (!timed),
    .tick_o (tick)
  );

  // Bus answer: ack one cycle after the request, data loaded with it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      wb_dat_o <= (req && !wb_ack_o) ? rd_nxt : wb_dat_o;
    end
  end

  // Control and software-visible state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r   <= aqs_pkg::CTL_RST;
      stmr_r  <= aqs_pkg::STMR_RST;
      run_r   <= 1'b0;
      sie_r   <= 1'b0;
      avail_r <= 1'b0;
      ovf_r   <= 1'b0;
      terr_r  <= 1'b0;
      ierr_r  <= 1'b0;
      irq_o   <= 1'b0;
    end else begin
      ctl_r   <= ctl_take ? wb_dat_i[10:0] : ctl_r;
      stmr_r  <= wr_stmr ? wb_dat_i[15:0] : stmr_r;
      sie_r   <= wr_sctl ? wb_dat_i[aqs_pkg::SCTL_IE_BIT] : sie_r;
      run_r   <= wr_sctl ? (wb_dat_i[aqs_pkg::SCTL_RUN_BIT] &&
                            (seq_on || first[5])) :
                 (halt ? 1'b0 : run_r);
      avail_r <= seq_end || (avail_r && !clr_avail);
      ovf_r   <= ovf_set || (ovf_r && !clr_ovf);
      terr_r  <= terr_set || (terr_r && !clr_terr);
      ierr_r  <= ierr_set || (ierr_r && !clr_ierr);
      irq_o   <= irq_nxt;
    end
  end

  // Settling, conversion timing and the multiplexer drive.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_cnt_r <= '0;
      conv_cnt_r   <= '0;
      settle_seq_r <= 1'b0;
      conv_seq_r   <= 1'b0;
      adc_start_o  <= 1'b0;
      mux_chan_o   <= 5'h00;
      mux_diff_o   <= 1'b0;
      gain_o       <= 2'h0;
    end else begin
      settle_cnt_r <= ctl_take ? ctl_settle :
                      seq_mux ? aqs_pkg::SETTLE_CYC :
                      settle_active ? settle_cnt_r - CW'(1) : '0;
      settle_seq_r <= ctl_take ? 1'b0 : (seq_mux ? 1'b1 : settle_seq_r);
      adc_start_o  <= cnv_take || auto_go || seq_go;
      conv_cnt_r   <= adc_start_o ? aqs_pkg::CONV_CYC :
                      conv_active ? conv_cnt_r - CW'(1) : '0;
      conv_seq_r   <= (cnv_take || auto_go) ? 1'b0 :
                      (seq_go ? 1'b1 : conv_seq_r);
      mux_chan_o   <= seq_mux ? seq_tgt :
                      ctl_take ? wb_dat_i[4:0] : mux_chan_o;
      mux_diff_o   <= seq_mux ? tgt_word[aqs_pkg::INS_DIFF_BIT] :
                      ctl_take ? wb_dat_i[aqs_pkg::CTL_DIFF_BIT] :
                      mux_diff_o;
      gain_o       <= seq_mux ? tgt_word[1:0] :
                      ctl_take ? wb_dat_i[7:6] : gain_o;
    end
  end

  // Result register and sequencer walk.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_r    <= 12'h000;
      prev_r      <= 12'h000;
      sq_r        <= aqs_pkg::SQ_IDLE;
      cur_r       <= 5'h00;
      pcnt_r      <= 16'h0000;
      terr_pend_r <= 1'b0;
    end else begin
      result_r    <= conv_evt ? (pipe_m ? prev_r : adc_data_i) :
                     result_r;
      prev_r      <= conv_evt ? adc_data_i : prev_r;
      sq_r        <= sq_nxt;
      cur_r       <= (seq_start || seq_end) ? first[4:0] :
                     (seq_store ? after_cur[4:0] : cur_r);
      pcnt_r      <= !timed ? 16'h0000 :
                     period_hit ? 16'h0000 :
                     tick ? pcnt_r + 16'h0001 : pcnt_r;
      terr_pend_r <= !seq_on ? 1'b0 : (terr_pend_r || terr_set);
    end
  end

  for (genvar i = 0; i < aqs_pkg::NCH; i++) begin : g_ch
    wire is_cur = (cur_r == 5'(i));
    assign ena[i] = iram_r[i][aqs_pkg::INS_EN_BIT];
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        iram_r[i]   <= 4'h0;
        shadow_r[i] <= 12'h000;
        dram_r[i]   <= 12'h000;
      end else begin
        iram_r[i]   <= (wr_iram && ridx == 5'(i)) ? wb_dat_i[3:0] :
                       iram_r[i];
        shadow_r[i] <= (seq_store && is_cur) ? adc_data_i : shadow_r[i];
        dram_r[i]   <= (cont_m && seq_store && is_cur) ? adc_data_i :
                       (commit && ena[i]) ?
                       (is_cur ? adc_data_i : shadow_r[i]) :
                       dram_r[i];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_mode_bits_take: assert property (ctl_take |=>
    auto_m == $past(wr_auto) && pipe_m == $past(wr_pipe))
    else $error("mode bits not taken from control write");
  a_normal_apply: assert property (ctl_take && !wr_auto |=>
    mux_chan_o == $past(wb_dat_i[4:0]) && settle_cnt_r == 10'h177)
    else $error("normal write not applied");
  a_pipe_result: assert property (conv_evt |=>
    result_r == (pipe_m ? $past(prev_r) : $past(adc_data_i)))
    else $error("result placement wrong");
  a_auto_start: assert property (auto_go |=> adc_start_o ##1
    conv_cnt_r == 10'h271)
    else $error("automatic start missing");
  a_settle_flag: assert property (ctl_take ##1 !ctl_take[*8] |->
    settle_active)
    else $error("settling flag dropped early");
  a_conv_flag: assert property (adc_start_o |=> conv_active[*8])
    else $error("conversion flag dropped early");
  a_auto_one_irq: assert property (settle_done && auto_m && !seq_on &&
    !settle_seq_r && !conv_done && !sie_r |=> !irq_o)
    else $error("settle interrupt in automatic mode");
  a_seq_avail: assert property (seq_end |=> avail_r)
    else $error("data available not set at sequence end");
  a_avail_w1c: assert property (clr_avail && !seq_end |=> !avail_r)
    else $error("data available not cleared");
  a_ovf_cont: assert property (cont_m |-> !rd_nxt[1] ||
    adr != aqs_pkg::OFS_SSTAT)
    else $error("overflow reads one in continuous mode");
  a_ierr_stop: assert property (ierr_set |=> ierr_r && !run_r && !seq_on)
    else $error("empty instruction start not refused");

  c_seq_cont: cover property (seq_end && cont_m);
  c_seq_timer: cover property (commit ##[1:1000] period_hit);
  c_terr: cover property (terr_set);
  c_pipe_conv: cover property (conv_evt && pipe_m && auto_m);
endmodule : aqs_sequencer
`default_nettype wire

// ---- testbench/aqs_conv_model.sv ----
`default_nettype none
module aqs_conv_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Multiplexer and converter
  input  wire logic [4:0]  mux_chan_o,
  input  wire logic        mux_diff_o,
  input  wire logic [1:0]  gain_o,
  input  wire logic        adc_start_o,
  output var  logic [11:0] adc_data_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] val_r;
  logic [11:0] junk_r;
  logic [9:0]  cnt_r;
  logic [3:0]  n_r;
  logic [7:0]  sel_q;
  // Outside a conversion the data lines wander, so a late sample shows.
  assign adc_data_i = (cnt_r != 10'h000) ? val_r : ~val_r ^ junk_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      val_r  <= 12'h000;
      junk_r <= 12'h000;
      cnt_r  <= 10'h000;
      n_r    <= 4'h0;
      sel_q  <= 8'h00;
    end else begin
      junk_r <= junk_r + 12'h001;
      // The input is held as it stood when the start pulse rose.
      sel_q  <= {mux_chan_o, mux_diff_o, gain_o};
      if (adc_start_o) begin
        val_r <= {sel_q, n_r};
        cnt_r <= 10'h272;
        n_r   <= n_r + 4'h1;
      end else if (cnt_r != 10'h000) begin
        cnt_r <= cnt_r - 10'h001;
      end
    end
  end
endmodule : aqs_conv_model
`default_nettype wire

// ---- testbench/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [8:0]  adr = 9'h000;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [11:0] adc;
  logic [4:0]  mch;
  logic [1:0]  mg;
  logic        ack, md, st, irq;
  int n_errors = 0, n_compared = 0, n_irq = 0, n_conv = 0, cyc_n = 0;

  always #10 clk = ~clk;
  always @(posedge clk) cyc_n <= cyc_n + 1;
  always @(posedge clk) if (irq === 1'b1) n_irq <= n_irq + 1;

  aqs_sequencer #(.STEP_CYC(20)) dut (.clk(clk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .adc_data_i(adc), .mux_chan_o(mch), .mux_diff_o(md), .gain_o(mg),
    .adc_start_o(st), .irq_o(irq));
  aqs_conv_model conv (.clk(clk), .rst(rst), .mux_chan_o(mch),
    .mux_diff_o(md), .gain_o(mg), .adc_start_o(st), .adc_data_i(adc));

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [8:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (t >= 50) chk(32'h0000_0000, 32'h0000_0001);
  endtask : wb

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [8:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'($urandom), q);
  endtask : rd

  task automatic chkr(input logic [8:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    chk(q, e);
  endtask : chkr

  // Polls the acquisition status until the masked flags are clear.
  task automatic wait_stat(input logic [31:0] m);
    logic [31:0] q;
    int t;
    t = 0;
    do begin
      rd(aqs_pkg::OFS_STAT, q);
      t++;
    end while ((q & m) != 32'h0000_0000 && t < 400);
    chk(q & m, 32'h0000_0000);
  endtask : wait_stat

  task automatic wait_irq(input int n);
    int t;
    t = 0;
    while (n_irq < n && t < 30000) begin
      @(negedge clk);
      t++;
    end
    chk(32'(n_irq), 32'(n));
  endtask : wait_irq

  function automatic logic [31:0] ctlw(logic [4:0] c, logic d,
    logic [1:0] g, logic au, logic p, logic ie);
    return {21'h00_0000, ie, p, au, g, d, c};
  endfunction : ctlw

  function automatic logic [31:0] ev(logic [4:0] c, logic d,
    logic [1:0] g, int k);
    return {20'h0_0000, c, d, g, k[3:0]};
  endfunction : ev

  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  initial begin
    logic [31:0] q, en;
    logic [4:0]  c;
    logic        d;
    logic [1:0]  g;
    int          k, ne, t0;
    void'($urandom(56));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chkr(aqs_pkg::OFS_STAT, 32'h0000_0000);
    chkr(aqs_pkg::OFS_SSTAT, 32'h0000_0000);
    chkr(aqs_pkg::OFS_RES, 32'h0000_0000);
    chkr(9'h1F0, 32'h0000_0000);
    $display("test reset done");
    c = 5'($urandom);
    d = 1'($urandom);
    g = 2'($urandom);
    wr(aqs_pkg::OFS_CTL, ctlw(c, d, g, 1'b0, 1'b0, 1'b1));
    chkr(aqs_pkg::OFS_STAT, 32'h0000_0002);
    chk({24'h00_0000, mch, md, mg}, {24'h00_0000, c, d, g});
    wait_stat(32'h0000_0002);
    chk(32'(n_irq), 32'h0000_0001);
    wr(aqs_pkg::OFS_CONV, 32'($urandom));
    chkr(aqs_pkg::OFS_STAT, 32'h0000_0001);
    wait_stat(32'h0000_0001);
    chkr(aqs_pkg::OFS_RES, ev(c, d, g, n_conv));
    n_conv++;
    chk(32'(n_irq), 32'h0000_0002);
    $display("test normal done");
    wr(aqs_pkg::OFS_CTL, ctlw(c, d, g, 1'b0, 1'b1, 1'b0));
    wait_stat(32'h0000_0002);
    k = n_conv;
    wr(aqs_pkg::OFS_CONV, 32'h0000_0000);
    wait_stat(32'h0000_0001);
    wr(aqs_pkg::OFS_CONV, 32'h0000_0000);
    wr(aqs_pkg::OFS_CTL, ctlw(c + 5'h01, d, g, 1'b0, 1'b1, 1'b0));
    chkr(aqs_pkg::OFS_STAT, 32'h0000_0003);
    wait_stat(32'h0000_0003);
    n_conv += 2;
    chkr(aqs_pkg::OFS_RES, ev(c, d, g, k));
    chk(32'(n_irq), 32'h0000_0002);
    $display("test pipelined done");
    wr(aqs_pkg::OFS_CTL, ctlw(c + 5'h01, d, g, 1'b1, 1'b1, 1'b1));
    wait_irq(3);
    chkr(aqs_pkg::OFS_STAT, 32'h0000_0000);
    chkr(aqs_pkg::OFS_RES, ev(c, d, g, k + 1));
    n_conv++;
    wr(aqs_pkg::OFS_CTL, ctlw(c, d, g, 1'b1, 1'b0, 1'b1));
    wait_irq(4);
    chkr(aqs_pkg::OFS_STAT, 32'h0000_0000);
    chkr(aqs_pkg::OFS_RES, ev(c, d, g, n_conv));
    n_conv++;
    wr(aqs_pkg::OFS_CONV, 32'h0000_0000);
    chkr(aqs_pkg::OFS_STAT, 32'h0000_0000);
    $display("test automatic done");
    for (int i = 0; i < 32; i++) wr(9'(32'h80 + 4 * i), 32'h0000_0000);
    wr(aqs_pkg::OFS_SCTL, 32'h0000_0001);
    chkr(aqs_pkg::OFS_SSTAT, 32'h0000_0008);
    wr(aqs_pkg::OFS_SSTAT, 32'h0000_0008);
    chkr(aqs_pkg::OFS_SSTAT, 32'h0000_0000);
    en = (32'h1 << ($urandom % 32)) | (32'h1 << ($urandom % 32));
    ne = $countones(en);
    for (int i = 0; i < 32; i++)
      wr(9'(32'h80 + 4 * i), {28'h000_0000, en[i], d, g});
    wr(aqs_pkg::OFS_STMR, 32'h0000_03E8);
    t0 = cyc_n;
    wr(aqs_pkg::OFS_SCTL, 32'h0000_0003);
    wait_irq(5);
    chk(32'(cyc_n - t0 <= 600 + 625 * ne), 32'h0000_0001);
    rd(aqs_pkg::OFS_SSTAT, q);
    chk(q & 32'h0000_000F, 32'h0000_0001);
    for (int i = 0; i < 32; i++) begin
      rd(9'(32'h100 + 4 * i), q);
      chk(q, en[i] ? ev(5'(i), d, g, n_conv) : 32'h0000_0000);
      if (en[i]) n_conv++;
    end
    wr(aqs_pkg::OFS_SSTAT, 32'h0000_0001);
    rd(aqs_pkg::OFS_SSTAT, q);
    chk(q & 32'h0000_0001, 32'h0000_0000);
    wr(aqs_pkg::OFS_SCTL, 32'h0000_0000);
    $display("test sequencer timer done");
    wr(aqs_pkg::OFS_STMR, 32'h0000_0000);
    wr(aqs_pkg::OFS_SCTL, 32'h0000_0003);
    wait_irq(7);
    rd(aqs_pkg::OFS_SSTAT, q);
    chk(q & 32'h0000_0003, 32'h0000_0001);
    for (int i = 0; i < 32; i++) begin
      rd(9'(32'h100 + 4 * i), q);
      chk(q & 32'h0000_0FF0, en[i] ? ev(5'(i), d, g, 0) : 0);
    end
    wr(aqs_pkg::OFS_SCTL, 32'h0000_0000);
    $display("test sequencer continuous done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
